// ---- logic/bstap_cfg.svh ----
// Configuration constants for the boundary-scan test access port
`ifndef BSTAP_CFG_SVH
`define BSTAP_CFG_SVH

// ----------------------------------------
// Device size selection, 0..5 smallest to largest
// ----------------------------------------
`define BSTAP_DEV_SEL 2
`define BSTAP_HAS_BSR (`BSTAP_DEV_SEL >= 2)
`define BSTAP_BSR_LEN ((`BSTAP_DEV_SEL == 2) ? 288 : (`BSTAP_DEV_SEL == 3) ? 312 : \
                       (`BSTAP_DEV_SEL == 4) ? 360 : (`BSTAP_DEV_SEL == 5) ? 480 : 3)
`define BSTAP_CELLS_PER_PIN 3
`define BSTAP_NPIN (`BSTAP_BSR_LEN / `BSTAP_CELLS_PER_PIN)
`define BSTAP_CELL_IN 0
`define BSTAP_CELL_OUT 1
`define BSTAP_CELL_OE 2

// ----------------------------------------
// Instruction register
// ----------------------------------------
`define BSTAP_IR_LEN 10
`define BSTAP_IR_CAPT 10'h001
`define BSTAP_OP_EXTEST 10'h000
`define BSTAP_OP_SAMPLE 10'h005
`define BSTAP_OP_IDCODE 10'h006
`define BSTAP_OP_BYPASS 10'h3FF
`define BSTAP_OP_ISP_EN 10'h2CC
`define BSTAP_OP_ISP_PROG 10'h2F4
`define BSTAP_OP_ISP_READ 10'h205
`define BSTAP_OP_ISP_DIS 10'h201

// ----------------------------------------
// Identification register (field values arbitrary)
// ----------------------------------------
`define BSTAP_ID_LEN 32
`define BSTAP_ID_VER 4'h1
`define BSTAP_ID_PART 16'h1234
`define BSTAP_ID_MFR 11'h0A5
`define BSTAP_ID_LSB 1'h1

`endif

// ---- logic/bstap_pkg.sv ----
// Types shared by the boundary-scan test access port
`include "bstap_cfg.svh"
package bstap_pkg;
  // ----------------------------------------
  // Controller states, one-hot
  // ----------------------------------------
  typedef enum logic [15:0] {
    TAP_TLR = 16'h0001, TAP_RTI = 16'h0002, TAP_SDRS = 16'h0004, TAP_CDR = 16'h0008,
    TAP_SDR = 16'h0010, TAP_E1DR = 16'h0020, TAP_PDR = 16'h0040, TAP_E2DR = 16'h0080,
    TAP_UDR = 16'h0100, TAP_SIRS = 16'h0200, TAP_CIR = 16'h0400, TAP_SIR = 16'h0800,
    TAP_E1IR = 16'h1000, TAP_PIR = 16'h2000, TAP_E2IR = 16'h4000, TAP_UIR = 16'h8000
  } bstap_state_t;

  typedef enum logic [2:0] {
    SEL_BYP = 3'h1, SEL_IDC = 3'h2, SEL_BSR = 3'h4
  } bstap_sel_t;

  // ----------------------------------------
  // Pin bundles
  // ----------------------------------------
  typedef struct packed {
    logic tms;
    logic tdi;
  } bstap_jtag_in_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } bstap_jtag_out_t;

  // ----------------------------------------
  // Module state records
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] rst_sy;
    logic [1:0] en_sy;
    bstap_state_t tap;
    logic [`BSTAP_IR_LEN-1:0] ir_sh;
    logic [`BSTAP_IR_LEN-1:0] ir;
    logic byp;
    logic [`BSTAP_ID_LEN-1:0] id_sh;
    logic upd_tgl;
    logic ext;
    logic in_system_programming;
    logic [`BSTAP_NPIN-1:0] pin_m;
    logic [`BSTAP_NPIN-1:0] pin_s;
    logic [`BSTAP_NPIN-1:0] cout_m;
    logic [`BSTAP_NPIN-1:0] cout_s;
    logic [`BSTAP_NPIN-1:0] coe_m;
    logic [`BSTAP_NPIN-1:0] coe_s;
  } bstap_tck_st_t;

  typedef struct packed {
    logic [1:0] en_sy;
    logic en;
    logic [2:0] tgl_sy;
    logic [1:0] ext_sy;
    logic [1:0] isp_sy;
    logic [`BSTAP_BSR_LEN-1:0] upd;
    logic [`BSTAP_NPIN-1:0] pin_out;
    logic [`BSTAP_NPIN-1:0] pin_oe;
    logic [`BSTAP_NPIN-1:0] pin_m;
    logic [`BSTAP_NPIN-1:0] pin_s;
    logic [2:0] user_m;
    logic [2:0] user;
    logic user_tdo;
    logic user_tdo_oe;
  } bstap_core_st_t;

  typedef struct packed {
    logic [`BSTAP_BSR_LEN-1:0] sh;
    logic [`BSTAP_BSR_LEN-1:0] up;
  } bstap_bsr_st_t;
endpackage

// ---- logic/bstap_bsr.sv ----
// Boundary register: capture/shift stage and update stage
`timescale 1ns/10ps
`default_nettype none
`include "bstap_cfg.svh"
module bstap_bsr (
  // Test clock and reset
  input wire logic tck_i,
  input wire logic rst_i,
  // Scan control
  input wire logic capture_i,
  input wire logic shift_i,
  input wire logic update_i,
  input wire logic si_i,
  // Parallel data
  input wire logic [`BSTAP_BSR_LEN-1:0] par_i,
  output logic so_o,
  output logic [`BSTAP_BSR_LEN-1:0] upd_o
);
  import bstap_pkg::*;

  bstap_bsr_st_t st_ff;
  bstap_bsr_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (capture_i) begin
      nxt_st.sh = par_i;
    end else if (shift_i) begin
      nxt_st.sh = {si_i, st_ff.sh[`BSTAP_BSR_LEN-1:1]};
    end
    // Update stage only moves at Update-DR so pins never see the ripple
    if (update_i) begin
      nxt_st.up = st_ff.sh;
    end
    if (rst_i) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge tck_i) begin
    st_ff <= nxt_st;
  end

  assign so_o = st_ff.sh[0];
  assign upd_o = st_ff.up;

  a_bsr_update: assert property (@(posedge tck_i) disable iff (rst_i) update_i |=> upd_o == $past(st_ff.sh)) // see RQ3
    else $error("Boundary update stage did not take the shifted pattern");
endmodule
`default_nettype wire

// ---- logic/bstap_tap.sv ----
// Boundary-scan test access port: controller, instruction and data registers, pin muxing
//
// What this block does
// RQ1: Test port controller, registers and serial protocol follow the 1990 boundary-scan standard.
// RQ2: Instruction register is ten bits; update takes the ten shifted bits.
// RQ3: Sample/preload captures pins without disturbing them and preloads the output pattern.
// RQ4: External test drives outputs from the boundary pattern and captures input pins.
// RQ5: Bypass puts one register stage between TDI and TDO; core keeps running.
// RQ6: Identification register scans out on TDO, least significant bit first.
// RQ7: Identification is 32 bits: version, part number, manufacturer, constant bit.
// RQ8: Boundary length is 288, 312, 360 or 480 cells by device size.
// RQ9: Smallest two sizes route external test and sample/preload to bypass.
// RQ10: Programming instructions are accepted through the same four-pin port.
// RQ11: With the test interface unused, the four pins serve as user pins.
// RQ12: Identification least significant bit always reads one.
// RQ13: Reset puts the controller in test-logic-reset with identification selected.
// RQ14: Programming opcodes are implementation-defined; unused codes select bypass.
`timescale 1ns/10ps
`default_nettype none
`include "bstap_cfg.svh"
module bstap_tap (
  // Core clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Test port
  input wire logic tck_i,
  input wire bstap_pkg::bstap_jtag_in_t jtag_i,
  output var bstap_pkg::bstap_jtag_out_t jtag_o,
  // Test interface enable strap and user use of the port pins
  input wire logic jtag_en_i,
  input wire logic user_tdo_i,
  input wire logic user_tdo_oe_i,
  output logic [2:0] user_pin_o,
  // Core side of the user pins
  input wire logic [`BSTAP_NPIN-1:0] core_out_i,
  input wire logic [`BSTAP_NPIN-1:0] core_oe_i,
  output logic [`BSTAP_NPIN-1:0] core_in_o,
  // Device pins
  input wire logic [`BSTAP_NPIN-1:0] pin_in_i,
  output logic [`BSTAP_NPIN-1:0] pin_out_o,
  output logic [`BSTAP_NPIN-1:0] pin_oe_o,
  // Mode status to the core
  output logic ext_test_o,
  output logic isp_active_o
);
  import bstap_pkg::*;

  localparam int NPIN = `BSTAP_NPIN;
  localparam logic HAS_BSR = `BSTAP_HAS_BSR;
  localparam logic [`BSTAP_ID_LEN-1:0] ID_VALUE = {`BSTAP_ID_VER, `BSTAP_ID_PART, `BSTAP_ID_MFR, `BSTAP_ID_LSB};

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic is_isp(input logic [`BSTAP_IR_LEN-1:0] op);
    is_isp = (op == `BSTAP_OP_ISP_EN) || (op == `BSTAP_OP_ISP_PROG) ||
             (op == `BSTAP_OP_ISP_READ) || (op == `BSTAP_OP_ISP_DIS);
  endfunction

  function automatic bstap_sel_t dr_sel(input logic [`BSTAP_IR_LEN-1:0] op);
    if (op == `BSTAP_OP_IDCODE) begin
      dr_sel = SEL_IDC;
    end else if (HAS_BSR && (op == `BSTAP_OP_EXTEST || op == `BSTAP_OP_SAMPLE)) begin
      dr_sel = SEL_BSR; // see RQ3 see RQ4
    end else begin
      // Programming, bypass, unused codes and boundary codes on small parts
      dr_sel = SEL_BYP; // see RQ9 see RQ14 see RQ10
    end
  endfunction

  function automatic bstap_state_t tap_next(input bstap_state_t s, input logic tms);
    case (s)
      TAP_TLR: tap_next = tms ? TAP_TLR : TAP_RTI;
      TAP_RTI: tap_next = tms ? TAP_SDRS : TAP_RTI;
      TAP_SDRS: tap_next = tms ? TAP_SIRS : TAP_CDR;
      TAP_CDR: tap_next = tms ? TAP_E1DR : TAP_SDR;
      TAP_SDR: tap_next = tms ? TAP_E1DR : TAP_SDR;
      TAP_E1DR: tap_next = tms ? TAP_UDR : TAP_PDR;
      TAP_PDR: tap_next = tms ? TAP_E2DR : TAP_PDR;
      TAP_E2DR: tap_next = tms ? TAP_UDR : TAP_SDR;
      TAP_UDR: tap_next = tms ? TAP_SDRS : TAP_RTI;
      TAP_SIRS: tap_next = tms ? TAP_TLR : TAP_CIR;
      TAP_CIR: tap_next = tms ? TAP_E1IR : TAP_SIR;
      TAP_SIR: tap_next = tms ? TAP_E1IR : TAP_SIR;
      TAP_E1IR: tap_next = tms ? TAP_UIR : TAP_PIR;
      TAP_PIR: tap_next = tms ? TAP_E2IR : TAP_PIR;
      TAP_E2IR: tap_next = tms ? TAP_UIR : TAP_SIR;
      TAP_UIR: tap_next = tms ? TAP_SDRS : TAP_RTI;
      default: tap_next = TAP_TLR;
    endcase
  endfunction

  // ----------------------------------------
  // Test clock domain
  // ----------------------------------------
  bstap_tck_st_t t_ff;
  bstap_tck_st_t nxt_t;
  bstap_core_st_t c_ff;
  bstap_core_st_t nxt_c;
  logic t_rst;
  bstap_sel_t sel;
  logic bsr_cap;
  logic bsr_shift;
  logic bsr_upd;
  logic bsr_so;
  logic [`BSTAP_BSR_LEN-1:0] bsr_par;
  logic [`BSTAP_BSR_LEN-1:0] bsr_upd_q;
  logic tdo_mux;
  logic tdo_ff;
  logic tdo_oe_ff;

  // Held in reset while the core reset runs or the port is strapped off
  assign t_rst = t_ff.rst_sy[1] | ~t_ff.en_sy[1]; // see RQ11
  assign sel = dr_sel(t_ff.ir);
  assign bsr_cap = (t_ff.tap == TAP_CDR) && (sel == SEL_BSR);
  assign bsr_shift = (t_ff.tap == TAP_SDR) && (sel == SEL_BSR);
  assign bsr_upd = (t_ff.tap == TAP_UDR) && (sel == SEL_BSR);

  genvar gp;
  generate
    for (gp = 0; gp < NPIN; gp++) begin : g_par
      assign bsr_par[gp*`BSTAP_CELLS_PER_PIN+`BSTAP_CELL_IN] = t_ff.pin_s[gp]; // see RQ3 see RQ4
      assign bsr_par[gp*`BSTAP_CELLS_PER_PIN+`BSTAP_CELL_OUT] = t_ff.cout_s[gp];
      assign bsr_par[gp*`BSTAP_CELLS_PER_PIN+`BSTAP_CELL_OE] = t_ff.coe_s[gp];
    end
  endgenerate

  bstap_bsr u_bsr (
    .tck_i(tck_i),
    .rst_i(t_ff.rst_sy[1]),
    .capture_i(bsr_cap),
    .shift_i(bsr_shift),
    .update_i(bsr_upd),
    .si_i(jtag_i.tdi),
    .par_i(bsr_par),
    .so_o(bsr_so),
    .upd_o(bsr_upd_q)
  ); // see RQ8

  always_comb begin
    nxt_t = t_ff;
    nxt_t.rst_sy = {t_ff.rst_sy[0], srst_i};
    nxt_t.en_sy = {t_ff.en_sy[0], c_ff.en};
    nxt_t.pin_m = pin_in_i;
    nxt_t.pin_s = t_ff.pin_m;
    nxt_t.cout_m = core_out_i;
    nxt_t.cout_s = t_ff.cout_m;
    nxt_t.coe_m = core_oe_i;
    nxt_t.coe_s = t_ff.coe_m;
    nxt_t.tap = tap_next(t_ff.tap, jtag_i.tms); // see RQ1
    case (t_ff.tap)
      TAP_TLR: begin
        nxt_t.ir = `BSTAP_OP_IDCODE; // see RQ13
      end
      TAP_CIR: begin
        nxt_t.ir_sh = `BSTAP_IR_CAPT;
      end
      TAP_SIR: begin
        nxt_t.ir_sh = {jtag_i.tdi, t_ff.ir_sh[`BSTAP_IR_LEN-1:1]}; // see RQ2
      end
      TAP_UIR: begin
        nxt_t.ir = t_ff.ir_sh; // see RQ2 see RQ10
      end
      TAP_CDR: begin
        nxt_t.byp = 1'h0;
        nxt_t.id_sh = ID_VALUE; // see RQ7 see RQ12
      end
      TAP_SDR: begin
        nxt_t.byp = jtag_i.tdi; // see RQ5
        nxt_t.id_sh = {jtag_i.tdi, t_ff.id_sh[`BSTAP_ID_LEN-1:1]}; // see RQ6
      end
      TAP_UDR: begin
        // Toggle tells the core domain that a new pattern is stable
        if (sel == SEL_BSR) begin
          nxt_t.upd_tgl = ~t_ff.upd_tgl;
        end
      end
      default: begin
      end
    endcase
    nxt_t.ext = HAS_BSR && (t_ff.ir == `BSTAP_OP_EXTEST); // see RQ4 see RQ9
    nxt_t.in_system_programming = is_isp(t_ff.ir); // see RQ10
    if (t_rst) begin
      nxt_t.tap = TAP_TLR; // see RQ13
      nxt_t.ir = `BSTAP_OP_IDCODE;
      nxt_t.ir_sh = '0;
      nxt_t.byp = 1'h0;
      nxt_t.id_sh = '0;
      nxt_t.ext = 1'h0;
      nxt_t.in_system_programming = 1'h0;
    end
    if (t_ff.rst_sy[1]) begin
      nxt_t.upd_tgl = 1'h0;
    end
  end

  always_ff @(posedge tck_i) begin
    t_ff <= nxt_t;
  end

  always_comb begin
    if (t_ff.tap == TAP_SIR) begin
      tdo_mux = t_ff.ir_sh[0];
    end else if (sel == SEL_IDC) begin
      tdo_mux = t_ff.id_sh[0]; // see RQ6
    end else if (sel == SEL_BSR) begin
      tdo_mux = bsr_so;
    end else begin
      tdo_mux = t_ff.byp; // see RQ5
    end
  end

  // TDO changes on the falling edge so the next device samples it cleanly
  always_ff @(negedge tck_i) begin
    if (t_rst) begin
      tdo_ff <= 1'h0;
      tdo_oe_ff <= 1'h0;
    end else begin
      tdo_ff <= tdo_mux; // see RQ1
      tdo_oe_ff <= (t_ff.tap == TAP_SIR) || (t_ff.tap == TAP_SDR);
    end
  end

  // ----------------------------------------
  // Core clock domain
  // ----------------------------------------
  always_comb begin
    nxt_c = c_ff;
    nxt_c.en_sy = {c_ff.en_sy[0], jtag_en_i};
    // Strap is caught while reset is held and frozen after
    if (srst_i) begin
      nxt_c.en = c_ff.en_sy[1];
    end
    nxt_c.tgl_sy = {c_ff.tgl_sy[1:0], t_ff.upd_tgl};
    nxt_c.ext_sy = {c_ff.ext_sy[0], t_ff.ext};
    nxt_c.isp_sy = {c_ff.isp_sy[0], t_ff.in_system_programming};
    // Pattern is stable in the test domain once the toggle arrives
    if (c_ff.tgl_sy[2] != c_ff.tgl_sy[1]) begin
      nxt_c.upd = bsr_upd_q; // see RQ3
    end
    nxt_c.pin_m = pin_in_i;
    nxt_c.pin_s = c_ff.pin_m;
    nxt_c.user_m = {tck_i, jtag_i.tms, jtag_i.tdi};
    nxt_c.user = c_ff.en ? 3'h0 : c_ff.user_m; // see RQ11
    nxt_c.user_tdo = user_tdo_i;
    nxt_c.user_tdo_oe = user_tdo_oe_i;
    for (int p = 0; p < NPIN; p++) begin
      if (c_ff.isp_sy[1]) begin
        // Pins float during programming to avoid board conflicts
        nxt_c.pin_out[p] = 1'h0;
        nxt_c.pin_oe[p] = 1'h0;
      end else if (c_ff.ext_sy[1]) begin
        nxt_c.pin_out[p] = c_ff.upd[p*`BSTAP_CELLS_PER_PIN+`BSTAP_CELL_OUT]; // see RQ4
        nxt_c.pin_oe[p] = c_ff.upd[p*`BSTAP_CELLS_PER_PIN+`BSTAP_CELL_OE];
      end else begin
        nxt_c.pin_out[p] = core_out_i[p]; // see RQ3 see RQ5
        nxt_c.pin_oe[p] = core_oe_i[p];
      end
    end
    if (srst_i) begin
      nxt_c.ext_sy = '0;
      nxt_c.isp_sy = '0;
      nxt_c.tgl_sy = '0;
      nxt_c.upd = '0;
      nxt_c.pin_out = '0;
      nxt_c.pin_oe = '0;
      nxt_c.user = '0;
      nxt_c.user_tdo = 1'h0;
      nxt_c.user_tdo_oe = 1'h0;
    end
  end

  always_ff @(posedge clock_i) begin
    c_ff <= nxt_c;
  end

  assign pin_out_o = c_ff.pin_out;
  assign pin_oe_o = c_ff.pin_oe;
  assign core_in_o = c_ff.pin_s;
  assign user_pin_o = c_ff.user;
  assign ext_test_o = c_ff.ext_sy[1];
  assign isp_active_o = c_ff.isp_sy[1];
  assign jtag_o.tdo = c_ff.en ? tdo_ff : c_ff.user_tdo; // see RQ11
  assign jtag_o.tdo_oe = c_ff.en ? tdo_oe_ff : c_ff.user_tdo_oe;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_reset_idcode: assert property (@(posedge tck_i) t_rst |=> (t_ff.tap == TAP_TLR) && (t_ff.ir == `BSTAP_OP_IDCODE)) // see RQ13
    else $error("Reset did not reach test-logic-reset with identification");
  a_ir_capture: assert property (@(posedge tck_i) disable iff (t_rst) (t_ff.tap == TAP_CIR) |=> t_ff.ir_sh == `BSTAP_IR_CAPT) // see RQ2
    else $error("Instruction capture pattern wrong");
  a_ir_update: assert property (@(posedge tck_i) disable iff (t_rst) (t_ff.tap == TAP_UIR) |=> t_ff.ir == $past(t_ff.ir_sh)) // see RQ2
    else $error("Instruction update lost the shifted bits");
  a_bypass_stage: assert property (@(posedge tck_i) disable iff (t_rst) // see RQ5
    (t_ff.tap == TAP_SDR) && (sel == SEL_BYP) ##1 (t_ff.tap == TAP_SDR) && (sel == SEL_BYP)
      |-> t_ff.byp == $past(jtag_i.tdi) && tdo_mux == t_ff.byp)
    else $error("Bypass stage not one cycle");
  a_id_capture: assert property (@(posedge tck_i) disable iff (t_rst) // see RQ7
    (t_ff.tap == TAP_CDR) |=> t_ff.id_sh == ID_VALUE && t_ff.id_sh[0] == `BSTAP_ID_LSB)
    else $error("Identification capture value wrong");
  a_id_lsb_first: assert property (@(posedge tck_i) disable iff (t_rst) // see RQ6
    (t_ff.tap == TAP_CDR) && (sel == SEL_IDC) ##1 (t_ff.tap == TAP_SDR) |-> tdo_mux == `BSTAP_ID_LSB)
    else $error("Identification did not start with its constant bit");
  a_unused_bypass: assert property (@(posedge tck_i) disable iff (t_rst) // see RQ14
    (t_ff.ir != `BSTAP_OP_IDCODE) && (t_ff.ir != `BSTAP_OP_EXTEST) && (t_ff.ir != `BSTAP_OP_SAMPLE) |-> sel == SEL_BYP)
    else $error("Unused instruction did not select bypass");
  a_small_bypass: assert property (@(posedge tck_i) disable iff (t_rst) // see RQ9
    (sel == SEL_BSR) |-> HAS_BSR && ((t_ff.ir == `BSTAP_OP_EXTEST) || (t_ff.ir == `BSTAP_OP_SAMPLE)))
    else $error("Boundary register selected on a part without one");
  a_extest_pins: assert property (@(posedge clock_i) disable iff (srst_i) // see RQ4
    c_ff.ext_sy[1] && !c_ff.isp_sy[1] |=> pin_out_o[0] == $past(c_ff.upd[`BSTAP_CELL_OUT]))
    else $error("Pin not driven from boundary pattern");
  a_user_release: assert property (@(posedge clock_i) disable iff (srst_i) // see RQ11
    !c_ff.en |=> jtag_o.tdo_oe == $past(user_tdo_oe_i))
    else $error("Port pin not released to user logic");
endmodule
`default_nettype wire

// ---- logic/placeholder_end.sv ----
// Intentionally empty compile unit
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ---- bench/bstap_ctl_model.sv ----
// Model of the external test controller that drives the device's test port
`timescale 1ns/10ps
`default_nettype none
module bstap_ctl_model (
  // Test port toward the device
  output logic tck_o,
  output var bstap_pkg::bstap_jtag_in_t jtag_o,
  // Serial answer from the device
  input wire logic tdo_i
);
  import bstap_pkg::*;

  logic run;

  // ----------------------------------------
  // Test clock, 6 ns, stands low while run is off
  // ----------------------------------------
  initial begin
    tck_o = 1'h0;
    run = 1'h0;
    jtag_o = 2'h2;
    #1.7;
    forever begin
      #3;
      tck_o = run ? ~tck_o : 1'h0;
    end
  end

  // ----------------------------------------
  // Bit-level driving
  // ----------------------------------------
  // Lines change just after a rising edge and hold through the next one
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    jtag_o = {tms, tdi};
    @(posedge tck_o);
    tdo = tdi_sample();
    #1;
  endtask

  function automatic logic tdi_sample();
    return tdo_i;
  endfunction

  // Five mode-high edges reach reset from any state, then settle in idle
  task automatic go_idle();
    logic t;
    repeat (5) step(1'h1, 1'h0, t);
    step(1'h0, 1'h0, t);
  endtask

  // Idle, capture, n shifts, update, idle; instruction scans carry all opcodes
  task automatic scan(input logic is_ir, input int n, input logic [479:0] din,
                      output logic [479:0] dout);
    logic t;
    dout = '0;
    @(posedge tck_o);
    #1;
    step(1'h1, 1'h0, t);
    if (is_ir) begin
      step(1'h1, 1'h0, t);
    end
    step(1'h0, 1'h0, t);
    step(1'h0, 1'h0, t);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], t);
      dout[i] = t;
    end
    step(1'h1, 1'h0, t);
    step(1'h0, 1'h0, t);
  endtask
endmodule
`default_nettype wire

// ---- bench/bstap_tap_tb_top.sv ----
// Self-checking testbench of the boundary-scan test access port
`timescale 1ns/10ps
`default_nettype none
`include "bstap_cfg.svh"
module bstap_tap_tb_top;
  import bstap_pkg::*;

  localparam int NP = `BSTAP_NPIN;
  localparam int NB = `BSTAP_BSR_LEN;
  localparam logic [31:0] IDV = {`BSTAP_ID_VER, `BSTAP_ID_PART, `BSTAP_ID_MFR, 1'h1};

  logic clock_i, srst_i, jtag_en_i, user_tdo_i, user_tdo_oe_i, tck, tdo_w, ext_test, isp_act;
  bstap_jtag_in_t ji;
  bstap_jtag_out_t jo;
  logic [2:0] user_pin;
  logic [NP-1:0] core_out, core_oe, core_in, pin_in, pin_out, pin_oe;
  logic [479:0] d, v, pre;
  logic [7:0] be;
  bit bq[$];
  logic [7:0] lf = 8'h22;
  logic [9:0] ops [6] = '{`BSTAP_OP_BYPASS, 10'h155, `BSTAP_OP_ISP_EN, `BSTAP_OP_ISP_PROG,
                          `BSTAP_OP_ISP_READ, `BSTAP_OP_ISP_DIS};
  int n_fail = 0;
  int total_checks = 0;

  // A released serial output shows the inverse of its value, so a late enable shows as a mismatch
  assign tdo_w = jo.tdo_oe ? jo.tdo : ~jo.tdo;

  bstap_tap i_dut (.clock_i(clock_i), .srst_i(srst_i), .tck_i(tck), .jtag_i(ji), .jtag_o(jo),
    .jtag_en_i(jtag_en_i), .user_tdo_i(user_tdo_i), .user_tdo_oe_i(user_tdo_oe_i),
    .user_pin_o(user_pin), .core_out_i(core_out), .core_oe_i(core_oe), .core_in_o(core_in),
    .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe), .ext_test_o(ext_test),
    .isp_active_o(isp_act));

  bstap_ctl_model u_ctl (.tck_o(tck), .jtag_o(ji), .tdo_i(tdo_w));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    clock_i = 1'h0;
    forever #12.5 clock_i = ~clock_i;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic rnd(output logic [479:0] r);
    for (int i = 0; i < 60; i++) begin
      lf = lfsr(lf);
      r[i*8 +: 8] = lf;
    end
  endtask

  task automatic chk(input logic [479:0] got, input logic [479:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic load_ir(input logic [9:0] op);
    logic [479:0] r;
    u_ctl.scan(1'h1, 10, {470'h0, op}, r);
    chk(r[9:0], 10'h001, "instruction capture");
  endtask

  task automatic in_cells(input logic [479:0] got);
    logic [479:0] g, e;
    g = '0;
    e = '0;
    for (int p = 0; p < NP; p++) begin
      g[3*p] = got[3*p];
      e[3*p] = pin_in[p];
    end
    chk(g, e, "captured input cells");
  endtask

  task automatic pins_from(input logic [479:0] pat);
    logic [NP-1:0] o, e;
    for (int p = 0; p < NP; p++) begin
      o[p] = pat[3*p+1];
      e[p] = pat[3*p+2];
    end
    chk(pin_out, o, "pin drive");
    chk(pin_oe, e, "pin enable");
  endtask

  task automatic new_pins();
    rnd(v);
    pin_in = v[NP-1:0];
    rnd(v);
    core_out = v[NP-1:0];
    core_oe = v[NP+NP-1:NP];
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Any hang ends the run as a failure
  initial begin
    #2000000;
    n_fail++;
    give_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    srst_i = 1'h1;
    jtag_en_i = 1'h1;
    user_tdo_i = 1'h0;
    user_tdo_oe_i = 1'h0;
    core_out = '0;
    core_oe = '0;
    pin_in = '0;
    waitc(1);
    u_ctl.run = 1'h1;
    waitc(5);
    srst_i = 1'h0;
    waitc(2);
    u_ctl.go_idle();
    // Identification selected straight out of reset
    u_ctl.scan(1'h0, 32, 480'h0, d);
    chk(d[31:0], IDV, "identification after reset");
    // Bypass, unused and programming opcodes all give one stage of delay
    waitc(1);
    new_pins();
    foreach (ops[k]) begin
      load_ir(ops[k]);
      rnd(v);
      u_ctl.scan(1'h0, 8, v, d);
      // Queue model: the captured zero leads, each input bit leaves one shift later
      bq.delete();
      bq.push_back(1'h0);
      for (int i = 0; i < 8; i++) begin
        bq.push_back(v[i]);
        be[i] = bq.pop_front();
      end
      chk(d[7:0], be, "bypass stage");
      waitc(10);
      chk(isp_act, k >= 2, "programming status");
      if (k >= 2) begin
        chk(pin_oe, '0, "pins float while programming");
      end else begin
        chk(pin_oe, core_oe, "pins follow core in bypass");
      end
    end
    // Sample and preload while the core keeps the pins
    waitc(1);
    new_pins();
    waitc(10);
    load_ir(`BSTAP_OP_SAMPLE);
    rnd(pre);
    u_ctl.scan(1'h0, NB, pre, d);
    in_cells(d);
    waitc(10);
    chk(pin_out, core_out, "pins follow core under sample");
    chk(pin_oe, core_oe, "enables follow core under sample");
    chk(core_in, pin_in, "core sees pins");
    chk(ext_test, 1'h0, "no external test under sample");
    // External test drives the preloaded pattern, then a new one
    load_ir(`BSTAP_OP_EXTEST);
    waitc(10);
    chk(ext_test, 1'h1, "external test status");
    pins_from(pre);
    new_pins();
    waitc(10);
    rnd(v);
    u_ctl.scan(1'h0, NB + 8, v, d);
    in_cells(d);
    chk(d[NB +: 8], v[7:0], "boundary chain length");
    waitc(10);
    pins_from(v >> 8);
    // Mode-high walk to reset restores identification and core pins
    u_ctl.go_idle();
    u_ctl.scan(1'h0, 32, 480'h0, d);
    chk(d[31:0], IDV, "identification after mode reset");
    waitc(10);
    chk(ext_test, 1'h0, "external test left");
    chk(pin_out, core_out, "pins back to core");
    // Strap off: the four test pins serve the user
    u_ctl.run = 1'h0;
    jtag_en_i = 1'h0;
    srst_i = 1'h1;
    waitc(6);
    srst_i = 1'h0;
    u_ctl.jtag_o = 2'h2;
    user_tdo_i = 1'h1;
    user_tdo_oe_i = 1'h1;
    waitc(6);
    chk(user_pin, 3'h2, "user pins mode high");
    chk(jo, 2'h3, "user drive of serial out");
    u_ctl.jtag_o = 2'h1;
    user_tdo_i = 1'h0;
    waitc(6);
    chk(user_pin, 3'h1, "user pins data high");
    chk(jo, 2'h1, "user drive low");
    give_verdict();
  end
endmodule
`default_nettype wire
